// [hw/dace_core_end.sv]
`timescale 1ns/10ps
`include "dace_regs.svh"
module dace_core_end
	import dace_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [31:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	dace_if.core             link
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0]       ctrl0;
		logic [31:0]       ctrl2;
		logic [ADDR_W-1:0] cmp1;
		logic [ADDR_W-1:0] cmp2;
		logic [2:0]        machine_state_register;
		logic [ADDR_W-1:0] accPc;
		logic [ADDR_W-1:0] accAddr;
		logic              accValid;
		logic              accWr;
		logic              lastSup;
		logic [2:0]        events;
		logic [ADDR_W-1:0] evtPc;
		logic              stsClr;
		logic [4:0]        clrMask;
		logic              resume;
		logic [31:0]       rdata;
		logic              ready;
		logic              err;
	} dace_core_type;

	dace_core_type core_r;
	dace_core_type core_nxt;

	logic       setup;
	logic       access;
	logic [7:0] offs;

	if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
		$error("dace_core_end: ADDR_W out of range");
	end

	assign setup  = psel && !penable;
	assign access = psel && penable && core_r.ready;
	assign offs   = paddr[7:0];

	always_comb begin
		core_nxt        = core_r;
		core_nxt.ready  = 1'h0;
		core_nxt.err    = 1'h0;
		core_nxt.stsClr = 1'h0;
		core_nxt.resume = 1'h0;
		// ----------------------------------------
		// apb read path, answered in the access cycle
		// ----------------------------------------
		if (setup) begin
			core_nxt.ready = 1'h1;
			core_nxt.rdata = 32'h0000_0000;
			case (offs)
				`DACE_A_CTRL0:   core_nxt.rdata = core_r.ctrl0;
				`DACE_A_CTRL2:   core_nxt.rdata = core_r.ctrl2;
				`DACE_A_CMP1:    core_nxt.rdata = 32'(core_r.cmp1);
				`DACE_A_CMP2:    core_nxt.rdata = 32'(core_r.cmp2);
				`DACE_A_MSR:     core_nxt.rdata = 32'(core_r.machine_state_register);
				`DACE_A_ACCPC:   core_nxt.rdata = 32'(core_r.accPc);
				`DACE_A_ACCADDR: core_nxt.rdata = 32'(core_r.accAddr);
				`DACE_A_ISSUE:   core_nxt.rdata = 32'({core_r.lastSup, core_r.accValid});
				`DACE_A_STATUS:  core_nxt.rdata = 32'(link.dbgStatus);
				`DACE_A_EVTPC:   core_nxt.rdata = 32'(core_r.evtPc);
				`DACE_A_EVENTS:  core_nxt.rdata = 32'(core_r.events);
				default:         core_nxt.err   = 1'h1;
			endcase
		end
		// ----------------------------------------
		// apb write path
		// ----------------------------------------
		if (access && pwrite) begin
			case (offs)
				`DACE_A_CTRL0:   core_nxt.ctrl0   = pwdata;
				`DACE_A_CTRL2:   core_nxt.ctrl2   = pwdata;
				`DACE_A_CMP1:    core_nxt.cmp1    = pwdata[ADDR_W-1:0];
				`DACE_A_CMP2:    core_nxt.cmp2    = pwdata[ADDR_W-1:0];
				`DACE_A_MSR:     core_nxt.machine_state_register     = pwdata[2:0];
				`DACE_A_ACCPC:   core_nxt.accPc   = pwdata[ADDR_W-1:0];
				`DACE_A_ACCADDR: core_nxt.accAddr = pwdata[ADDR_W-1:0];
				`DACE_A_ISSUE: begin
					// no issue while one is open or the device has stopped
					if (!core_r.accValid && !core_r.events[`DACE_EV_STOP]) begin
						core_nxt.accValid = 1'h1;
						core_nxt.accWr    = pwdata[0];
					end
				end
				`DACE_A_STATUS: begin
					core_nxt.stsClr  = 1'h1;
					core_nxt.clrMask = pwdata[4:0];
				end
				`DACE_A_EVENTS: begin
					core_nxt.events = core_r.events & ~pwdata[2:0];
					core_nxt.resume = pwdata[`DACE_EV_STOP];
				end
				default: begin
					// error already shown with pready; must not outlast the access
					core_nxt.err = 1'h0;
				end
			endcase
		end
		// ----------------------------------------
		// device answers, applied last so sets win
		// ----------------------------------------
		if (link.accDone) begin
			core_nxt.accValid = 1'h0;
			core_nxt.lastSup  = link.accSuppress;
		end
		if (link.stopReq) begin
			core_nxt.events[`DACE_EV_STOP] = 1'h1;
			core_nxt.evtPc                 = link.evtPc;
		end
		if (link.irqReq) begin
			// taking the interrupt masks further ones, as a real core does
			core_nxt.events[`DACE_EV_IRQ] = 1'h1;
			core_nxt.evtPc                = link.evtPc;
			core_nxt.machine_state_register[`DACE_MSR_DE]    = 1'h0;
		end
		if (link.traceEvt) begin
			core_nxt.events[`DACE_EV_TRACE] = 1'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_r       <= '0;
			core_r.ctrl0 <= `DACE_REG_RST;
			core_r.ctrl2 <= `DACE_REG_RST;
		end else begin
			core_r <= core_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata          = core_r.rdata;
	assign pready          = core_r.ready;
	assign pslverr         = core_r.err;
	assign link.accValid   = core_r.accValid;
	assign link.accWrite   = core_r.accWr;
	assign link.accAddr    = core_r.accAddr;
	assign link.accPc      = core_r.accPc;
	assign link.msrPr      = core_r.machine_state_register[`DACE_MSR_PR];
	assign link.msrDs      = core_r.machine_state_register[`DACE_MSR_DS];
	assign link.msrDe      = core_r.machine_state_register[`DACE_MSR_DE];
	assign link.rdEn       = core_r.ctrl0[`DACE_C0_RDEN];
	assign link.wrEn       = core_r.ctrl0[`DACE_C0_WREN];
	assign link.modeExt    = core_r.ctrl0[`DACE_C0_EXT];
	assign link.modeWait   = core_r.ctrl0[`DACE_C0_WAIT];
	assign link.modeInt    = core_r.ctrl0[`DACE_C0_INT];
	assign link.modeTrace  = core_r.ctrl0[`DACE_C0_TRACE];
	assign link.privSel    = core_r.ctrl2[`DACE_C2_PRIV];
	assign link.spaceSel   = core_r.ctrl2[`DACE_C2_SPACE];
	assign link.valueBe    = core_r.ctrl2[`DACE_C2_BE];
	assign link.asyncSel   = core_r.ctrl2[`DACE_C2_ASYNC];
	assign link.cmpMode    = core_r.ctrl2[`DACE_C2_MODE];
	assign link.cmpAddr1   = core_r.cmp1;
	assign link.cmpAddr2   = core_r.cmp2;
	assign link.stsClr     = core_r.stsClr;
	assign link.stsClrMask = core_r.clrMask;
	assign link.resume     = core_r.resume;

endmodule : dace_core_end

// [hw/dace_event_unit.sv]
`timescale 1ns/10ps
`include "dace_regs.svh"
module dace_event_unit
	import dace_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	dace_if.dev       link,
	output logic      stopState
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		dace_state_type        st;
		logic [ADDR_W-1:0]     addr;
		logic [ADDR_W-1:0]     pc;
		logic                  isWr;
		logic                  pr;
		logic                  ds;
		logic                  de;
		logic                  done;
		logic                  suppress;
		logic                  stop;
		logic                  irq;
		logic                  trace;
		logic                  stopSt;
		logic                  lateStop;
		logic [ADDR_W-1:0]     evtPc;
		logic [`DACE_ST_W-1:0] status;
	} dace_dev_type;

	dace_dev_type state_r;
	dace_dev_type state_nxt;

	logic [1:0] addrHit;
	logic [1:0] privOk;
	logic [1:0] spaceOk;
	logic [1:0] beOff;
	logic [1:0] rdHit;
	logic [1:0] wrHit;
	logic [3:0] hits;
	logic       inRange;
	logic       stopMode;
	logic       intMode;
	logic       penalty;
	logic       dlyIrq;

	if (ADDR_W < 8 || ADDR_W > 64) begin : g_chk
		$error("dace_event_unit: ADDR_W out of range");
	end

	// ----------------------------------------
	// address compare
	// ----------------------------------------
	assign inRange = (state_r.addr >= link.cmpAddr1) && (state_r.addr < link.cmpAddr2);

	always_comb begin
		case (link.cmpMode)
			`DACE_MODE_EXACT: addrHit = {state_r.addr == link.cmpAddr2,
				state_r.addr == link.cmpAddr1};
			`DACE_MODE_MASK:  addrHit = {2{((state_r.addr ^ link.cmpAddr1) & link.cmpAddr2) == '0}};
			`DACE_MODE_INCL:  addrHit = {2{inRange}};
			`DACE_MODE_EXCL:  addrHit = {2{!inRange}};
			default:          addrHit = 2'h0;
		endcase
	end

	// reserved 01 selects never qualify; paired modes read each unit's own select
	for (genvar i = 0; i < `DACE_UNITS; i++) begin : g_unit
		assign privOk[i] = (link.privSel[i] == `DACE_PRIV_ANY)
			|| (link.privSel[i] == `DACE_PRIV_SUP && !state_r.pr)
			|| (link.privSel[i] == `DACE_PRIV_USR && state_r.pr);
		// only effective address and space bit; no process id input exists
		assign spaceOk[i] = (link.spaceSel[i] == `DACE_SPACE_EA)
			|| (link.spaceSel[i] == `DACE_SPACE_AS0 && !state_r.ds)
			|| (link.spaceSel[i] == `DACE_SPACE_AS1 && state_r.ds);
		assign beOff[i] = link.valueBe[i] == `DACE_BE_OFF;
		assign rdHit[i] = addrHit[i] & privOk[i] & spaceOk[i] & beOff[i]
			& !state_r.isWr & link.rdEn[i];
		assign wrHit[i] = addrHit[i] & privOk[i] & spaceOk[i] & beOff[i]
			& state_r.isWr & link.wrEn[i];
	end

	assign hits = {wrHit[1], rdHit[1], wrHit[0], rdHit[0]};

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	assign stopMode = link.modeExt | link.modeWait;
	assign intMode  = link.modeInt & !stopMode;
	// penalty is paid even when nothing hits: the check must finish first
	assign penalty  = (|link.rdEn | |link.wrEn) && (link.asyncSel == `DACE_SYNC)
		&& (stopMode | link.modeInt);
	assign dlyIrq   = state_r.status[`DACE_ST_IDE] && |state_r.status[`DACE_ST_HITS]
		&& intMode && link.msrDe && !state_r.irq;

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb begin
		state_nxt          = state_r;
		state_nxt.done     = 1'h0;
		state_nxt.suppress = 1'h0;
		state_nxt.stop     = 1'h0;
		state_nxt.irq      = 1'h0;
		state_nxt.trace    = 1'h0;
		if (link.stsClr) begin
			state_nxt.status = state_r.status & ~link.stsClrMask;
		end
		if (link.resume) begin
			state_nxt.stopSt = 1'h0;
		end
		case (state_r.st)
			DACE_IDLE: begin
				if (dlyIrq) begin
					state_nxt.irq   = 1'h1;
					state_nxt.evtPc = link.accPc;
				end else if (link.accValid && !state_r.done && !state_r.stopSt) begin
					state_nxt.addr = link.accAddr;
					state_nxt.pc   = link.accPc;
					state_nxt.isWr = link.accWrite;
					state_nxt.pr   = link.msrPr;
					state_nxt.ds   = link.msrDs;
					state_nxt.de   = link.msrDe;
					state_nxt.st   = penalty ? DACE_PEN : DACE_ACT;
				end
			end
			DACE_PEN: begin
				state_nxt.st = DACE_ACT;
			end
			DACE_ACT: begin
				state_nxt.done = 1'h1;
				state_nxt.st   = DACE_IDLE;
				// set after the clear above, so a same-cycle hit survives
				state_nxt.status[`DACE_ST_HITS] = state_nxt.status[`DACE_ST_HITS] | hits;
				if (|hits) begin
					if (stopMode && link.asyncSel == `DACE_SYNC) begin
						state_nxt.suppress = 1'h1;
						state_nxt.stop     = 1'h1;
						state_nxt.stopSt   = 1'h1;
						state_nxt.evtPc    = state_r.pc;
					end else if (intMode && state_r.de && link.asyncSel == `DACE_SYNC) begin
						state_nxt.suppress = 1'h1;
						state_nxt.irq      = 1'h1;
						state_nxt.evtPc    = state_r.pc;
					end else if (stopMode || (intMode && state_r.de)) begin
						state_nxt.lateStop = stopMode;
						state_nxt.st       = DACE_LATE;
					end else if (intMode) begin
						state_nxt.status[`DACE_ST_IDE] = 1'h1;
					end else if (link.modeTrace) begin
						state_nxt.trace = 1'h1;
					end
				end
			end
			DACE_LATE: begin
				// processed after completion: pc is the core's current one
				state_nxt.evtPc = link.accPc;
				state_nxt.st    = DACE_IDLE;
				if (state_r.lateStop) begin
					state_nxt.stop   = 1'h1;
					state_nxt.stopSt = 1'h1;
				end else begin
					state_nxt.irq = 1'h1;
				end
			end
			default: begin
				state_nxt.st = DACE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r        <= '0;
			state_r.st     <= DACE_IDLE;
			state_r.status <= `DACE_ST_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign link.accDone     = state_r.done;
	assign link.accSuppress = state_r.suppress;
	assign link.stopReq     = state_r.stop;
	assign link.irqReq      = state_r.irq;
	assign link.traceEvt    = state_r.trace;
	assign link.evtPc       = state_r.evtPc;
	assign link.dbgStatus   = state_r.status;
	assign stopState        = state_r.stopSt;

endmodule : dace_event_unit

// [inc/dace_if.sv]
`timescale 1ns/10ps
interface dace_if #(
	parameter int ADDR_W = 32
);
	logic                 accValid;
	logic                 accWrite;
	logic [ADDR_W-1:0]    accAddr;
	logic [ADDR_W-1:0]    accPc;
	logic                 msrPr;
	logic                 msrDs;
	logic                 msrDe;
	logic                 modeExt;
	logic                 modeWait;
	logic                 modeInt;
	logic                 modeTrace;
	logic [1:0]           rdEn;
	logic [1:0]           wrEn;
	logic [1:0][1:0]      privSel;
	logic [1:0][1:0]      spaceSel;
	logic [1:0][3:0]      valueBe;
	logic                 asyncSel;
	logic [1:0]           cmpMode;
	logic [ADDR_W-1:0]    cmpAddr1;
	logic [ADDR_W-1:0]    cmpAddr2;
	logic                 stsClr;
	logic [4:0]           stsClrMask;
	logic                 resume;
	logic                 accDone;
	logic                 accSuppress;
	logic                 stopReq;
	logic                 irqReq;
	logic                 traceEvt;
	logic [ADDR_W-1:0]    evtPc;
	logic [4:0]           dbgStatus;

	modport dev (
		input  accValid, accWrite, accAddr, accPc, msrPr, msrDs, msrDe,
		input  modeExt, modeWait, modeInt, modeTrace, rdEn, wrEn, privSel,
		input  spaceSel, valueBe, asyncSel, cmpMode, cmpAddr1, cmpAddr2,
		input  stsClr, stsClrMask, resume,
		output accDone, accSuppress, stopReq, irqReq, traceEvt, evtPc, dbgStatus
	);
	modport core (
		output accValid, accWrite, accAddr, accPc, msrPr, msrDs, msrDe,
		output modeExt, modeWait, modeInt, modeTrace, rdEn, wrEn, privSel,
		output spaceSel, valueBe, asyncSel, cmpMode, cmpAddr1, cmpAddr2,
		output stsClr, stsClrMask, resume,
		input  accDone, accSuppress, stopReq, irqReq, traceEvt, evtPc, dbgStatus
	);
endinterface : dace_if

// [inc/dace_pkg.sv]
package dace_pkg;
	typedef enum logic [1:0] {
		DACE_IDLE = 2'h0,
		DACE_PEN  = 2'h1,
		DACE_ACT  = 2'h3,
		DACE_LATE = 2'h2
	} dace_state_type;
endpackage : dace_pkg

// [inc/dace_regs.svh]
`ifndef DACE_REGS_SVH
`define DACE_REGS_SVH
// ----------------------------------------
// compare field encodings
// ----------------------------------------
`define DACE_UNITS      2
`define DACE_PRIV_ANY   2'h0
`define DACE_PRIV_SUP   2'h2
`define DACE_PRIV_USR   2'h3
`define DACE_SPACE_EA   2'h0
`define DACE_SPACE_AS0  2'h2
`define DACE_SPACE_AS1  2'h3
`define DACE_MODE_EXACT 2'h0
`define DACE_MODE_MASK  2'h1
`define DACE_MODE_INCL  2'h2
`define DACE_MODE_EXCL  2'h3
`define DACE_BE_OFF     4'h0
`define DACE_SYNC       1'h0
// ----------------------------------------
// status bits
// ----------------------------------------
`define DACE_ST_HITS    3:0
`define DACE_ST_IDE     4
`define DACE_ST_W       5
`define DACE_ST_RST     5'h00
// ----------------------------------------
// register offsets (paddr[7:0])
// ----------------------------------------
`define DACE_A_CTRL0    8'h00
`define DACE_A_CTRL2    8'h04
`define DACE_A_CMP1     8'h08
`define DACE_A_CMP2     8'h0C
`define DACE_A_MSR      8'h10
`define DACE_A_ACCPC    8'h14
`define DACE_A_ACCADDR  8'h18
`define DACE_A_ISSUE    8'h1C
`define DACE_A_STATUS   8'h20
`define DACE_A_EVTPC    8'h24
`define DACE_A_EVENTS   8'h28
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DACE_C0_RDEN    1:0
`define DACE_C0_WREN    3:2
`define DACE_C0_EXT     4
`define DACE_C0_WAIT    5
`define DACE_C0_INT     6
`define DACE_C0_TRACE   7
`define DACE_C2_PRIV    3:0
`define DACE_C2_SPACE   7:4
`define DACE_C2_BE      15:8
`define DACE_C2_ASYNC   16
`define DACE_C2_MODE    18:17
`define DACE_MSR_PR     0
`define DACE_MSR_DS     1
`define DACE_MSR_DE     2
`define DACE_EV_STOP    0
`define DACE_EV_IRQ     1
`define DACE_EV_TRACE   2
`define DACE_REG_RST    32'h0000_0000
`endif

// [tb/dace_props.sv]
`timescale 1ns/10ps
// ----------------------------------------
// event unit checker
// ----------------------------------------
module dace_props #(
	parameter int ADDR_W = 32
) (
	input logic              clk_sys,
	input logic              rst,
	input logic              accValid,
	input logic [ADDR_W-1:0] accPc,
	input logic              msrDe,
	input logic              modeExt,
	input logic              modeWait,
	input logic              modeInt,
	input logic [1:0]        rdEn,
	input logic [1:0]        wrEn,
	input logic [1:0][3:0]   valueBe,
	input logic              asyncSel,
	input logic              stsClr,
	input logic              accDone,
	input logic              accSuppress,
	input logic              stopReq,
	input logic              irqReq,
	input logic              traceEvt,
	input logic [ADDR_W-1:0] evtPc,
	input logic [4:0]        dbgStatus
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// config only moves between accesses, so the request edge sees the live setting
	logic penalty;
	assign penalty = (|rdEn || |wrEn) && !asyncSel && (modeExt || modeWait || modeInt);
	AST_DONE_FAST: assert property ($rose(accValid) && !penalty |-> !accDone [*2] ##1 accDone)
		else $error("access done not two cycles after request");
	AST_DONE_SLOW: assert property ($rose(accValid) && penalty |-> !accDone [*3] ##1 accDone)
		else $error("sync penalty cycle missing");
	AST_SUP_SYNC: assert property (accSuppress |-> accDone && !asyncSel && (modeExt || modeWait || (modeInt && msrDe)))
		else $error("suppress outside synchronous halt");
	AST_SYNC_STOP: assert property (accSuppress && (modeExt || modeWait) |-> stopReq && evtPc == accPc)
		else $error("sync stop missing or wrong pc");
	AST_ASYNC_STOP: assert property (stopReq && asyncSel |-> $past(accDone) && !accSuppress)
		else $error("async stop not after completion");
	AST_TRACE_ONLY: assert property (traceEvt |-> accDone && !accSuppress && !stopReq ##1 !stopReq && !irqReq)
		else $error("trace event with halt");
	AST_BE_BLOCK: assert property (accDone && |valueBe[0] && |valueBe[1] |-> !accSuppress && !traceEvt && !stopReq ##1 !stopReq && !irqReq)
		else $error("address event despite value enables");
	AST_IRQ_DE: assert property (irqReq |-> $past(msrDe) && modeInt && !modeExt && !modeWait)
		else $error("interrupt without enable");
	AST_STS_HOLD: assert property (!stsClr |=> (dbgStatus & $past(dbgStatus)) == $past(dbgStatus))
		else $error("status bit dropped without clear");
	cover property (accSuppress && stopReq);
	cover property (irqReq && asyncSel);
	cover property (traceEvt);
endmodule : dace_props

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "dace_regs.svh"
module tb_top;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, stopState, errv, isw;
	logic [31:0] paddr, pwdata, prdata, rdv, ctl2, c1, c2, acc, pc;
	logic [7:0]  ctl0;
	logic [2:0]  machine_state_register;
	logic [1:0]  md, p0, p1, s0, s1;
	logic [3:0]  be0, be1;
	logic [1:0]  ptab [3] = '{`DACE_PRIV_ANY, `DACE_PRIV_SUP, `DACE_PRIV_USR};
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int unsigned seed = 55;
	dace_if #(.ADDR_W(32)) link ();
	dace_core_end #(.ADDR_W(32)) dace_core_end_inst (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	dace_event_unit #(.ADDR_W(32)) dace_event_unit_inst (.clk_sys(clk_sys), .rst(rst),
		.link(link), .stopState(stopState));
	dace_props #(.ADDR_W(32)) dace_props_inst (.clk_sys(clk_sys), .rst(rst),
		.accValid(link.accValid), .accPc(link.accPc), .msrDe(link.msrDe), .modeExt(link.modeExt),
		.modeWait(link.modeWait), .modeInt(link.modeInt), .rdEn(link.rdEn), .wrEn(link.wrEn),
		.valueBe(link.valueBe), .asyncSel(link.asyncSel), .stsClr(link.stsClr),
		.accDone(link.accDone), .accSuppress(link.accSuppress), .stopReq(link.stopReq),
		.irqReq(link.irqReq), .traceEvt(link.traceEvt), .evtPc(link.evtPc),
		.dbgStatus(link.dbgStatus));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {24'h0, a};
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		chk("pready wait", 32'h1, n);
		rdv     = prdata;
		errv    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// reference model of one access, built from the compare rules
	function automatic logic [3:0] model();
		logic [3:0]  h;
		logic [1:0]  pv, sp;
		logic        m;
		logic [31:0] cv;
		h = 4'h0;
		for (int u = 0; u < 2; u++) begin
			pv = ctl2[2*u +: 2];
			sp = ctl2[4+2*u +: 2];
			cv = u ? c2 : c1;
			case (ctl2[18:17])
				2'h0: m = acc == cv;
				2'h1: m = (acc & c2) == (c1 & c2);
				2'h2: m = acc >= c1 && acc < c2;
				default: m = acc < c1 || acc >= c2;
			endcase
			m = m && (pv == 2'h0 || pv == {1'b1, machine_state_register[0]});
			m = m && (sp == 2'h0 || sp == {1'b1, machine_state_register[1]});
			m = m && ctl2[8+4*u +: 4] == 4'h0;
			h[2*u+isw] = m && ctl0[2*isw+u];
		end
		return h;
	endfunction : model
	task automatic access(input logic keep);
		logic [3:0] h;
		logic       stp, irq, trc, imp;
		h = model();
		stp = |h && |ctl0[5:4];
		irq = |h && ctl0[6] && machine_state_register[2] && !stp;
		imp = |h && ctl0[6] && !machine_state_register[2] && !stp;
		trc = |h && ctl0[7] && !(|ctl0[6:4]);
		apb(1'b1, `DACE_A_CTRL0, {24'h0, ctl0});
		apb(1'b1, `DACE_A_CTRL2, ctl2);
		apb(1'b1, `DACE_A_CMP1, c1);
		apb(1'b1, `DACE_A_CMP2, c2);
		apb(1'b1, `DACE_A_MSR, {29'h0, machine_state_register});
		apb(1'b1, `DACE_A_ACCPC, pc);
		apb(1'b1, `DACE_A_ACCADDR, acc);
		apb(1'b1, `DACE_A_ISSUE, {31'h0, isw});
		for (int n = 0; n < 20; n++) begin
			apb(1'b0, `DACE_A_ISSUE, 32'h0);
			if (rdv[0] === 1'b0) break;
		end
		chk("suppressed", {31'h0, (stp || irq) && !ctl2[16]}, {31'h0, rdv[1]});
		apb(1'b0, `DACE_A_STATUS, 32'h0);
		chk("status", {27'h0, imp, h}, rdv);
		apb(1'b0, `DACE_A_EVENTS, 32'h0);
		chk("events", {29'h0, trc, irq, stp}, rdv);
		chk("stopState", {31'h0, stp}, {31'h0, stopState});
		if (stp || irq) begin
			apb(1'b0, `DACE_A_EVTPC, 32'h0);
			chk("evtPc", pc, rdv);
		end
		if (!keep) begin
			apb(1'b1, `DACE_A_EVENTS, 32'h7);
			apb(1'b1, `DACE_A_STATUS, 32'h1F);
		end
	endtask : access
	// ----------------------------------------
	// clock, reset, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			$display("[FAIL] run length expected under 40000 seen %0d", cycles);
			stop_test();
		end
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (int o = 0; o <= 40; o += 4) begin
			apb(1'b0, 8'(o), 32'h0);
			chk("reset value", 32'h0, rdv);
		end
		apb(1'b0, 8'h2C, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, errv});
		chk("unmapped data", 32'h0, rdv);
		$display("test reset and decode done");
		// late enable must fire only while the status survives
		for (int k = 0; k < 2; k++) begin
			ctl0 = 8'h41;
			ctl2 = 32'h0;
			c1 = 32'h8;
			c2 = 32'h0;
			acc = 32'h8;
			machine_state_register = 3'h0;
			isw = 1'b0;
			pc = 32'h100;
			access(1'b1);
			if (k == 1) apb(1'b1, `DACE_A_STATUS, 32'h1F);
			apb(1'b1, `DACE_A_MSR, 32'h4);
			// irq pulse, then the core latches it: two edges before the read setup
			repeat (2) @(posedge clk_sys);
			apb(1'b0, `DACE_A_EVENTS, 32'h0);
			chk("delayed irq", {30'h0, k == 0, 1'b0}, rdv);
			apb(1'b1, `DACE_A_EVENTS, 32'h7);
			apb(1'b1, `DACE_A_STATUS, 32'h1F);
		end
		$display("test delayed interrupt done");
		for (int i = 0; i < 200; i++) begin
			ctl0 = 8'(8'h10 << (rnd() % 4)) | 8'(rnd() % 16);
			md = 2'(rnd());
			p0 = ptab[rnd() % 3];
			s0 = ptab[rnd() % 3];
			p1 = md != 2'h0 ? p0 : ptab[rnd() % 3];
			s1 = md != 2'h0 ? s0 : ptab[rnd() % 3];
			be0 = rnd() % 4 == 0 ? 4'(rnd()) : 4'h0;
			be1 = rnd() % 4 == 0 ? 4'(rnd()) : 4'h0;
			ctl2 = {13'h0, md, 1'(rnd()), be1, be0, s1, s0, p1, p0};
			c1 = rnd() % 64;
			c2 = rnd() % 64;
			// bias toward the compare values, a flat pick rarely hits exact mode
			acc = rnd() % 3 == 0 ? c1 : (rnd() % 2 ? c2 : rnd() % 64);
			machine_state_register = 3'(rnd());
			pc = rnd() & 32'hFFFFFFFC;
			isw = 1'(rnd());
			access(1'b0);
		end
		$display("test random events done");
		stop_test();
	end
endmodule : tb_top
